// ==== bench/pldc_host_model.sv ====
// system bus host model: cpu or dma side of the cell's register bus
`timescale 1ns/1ps
module pldc_host_model
	import pldc_pkg::*;
(
	// clock
	input  wire logic          clock,
	// system bus
	output logic [AW-1:0]      bus_addr,
	output logic               bus_wr,
	output logic               bus_rd,
	output logic [CW-1:0]      bus_wdata,
	input  wire logic [CW-1:0] bus_rdata,
	input  wire logic          bus_rvalid
);
	initial begin
		bus_addr = 5'h1F;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_wdata = 16'h0000;
	end
	// one write; config, setup and input queues are filled this way
	task automatic wr(input logic [AW-1:0] a, input logic [CW-1:0] d);
		@(negedge clock);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clock);
		bus_wr = 1'b0;
		bus_wdata = ~d; // released data no longer shows the last value
	endtask
	// one read, answer taken when rvalid shows, bounded wait
	task automatic rd(input logic [AW-1:0] a, output logic [CW-1:0] d);
		int n;
		@(negedge clock);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clock);
		bus_rd = 1'b0;
		n = 0;
		while (bus_rvalid !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		d = (bus_rvalid === 1'b1) ? bus_rdata : 16'hXXXX;
	endtask
endmodule

// ==== bench/tb.sv ====
// self-checking testbench of the programmable logic datapath cell
`timescale 1ns/1ps
module tb;
	import pldc_pkg::*;
	logic                              clock = 1'b0;
	logic                              resetn = 1'b0;
	logic [NROUTE-1:0]                 route_in = 6'h00;
	logic [1:0][PLD_IN-1:0]            pld_in = '0;
	logic [1:0][PLD_PT-1:0][PLD_IN-1:0] pld_and_true = '0;
	logic [1:0][PLD_OUT-1:0][PLD_PT-1:0] pld_or_sel = '0;
	logic [1:0][PLD_OUT-1:0]           pld_reg_sel = '0;
	wire logic [AW-1:0]                bus_addr;
	wire logic                         bus_wr, bus_rd, bus_rvalid;
	wire logic [CW-1:0]                bus_wdata, bus_rdata;
	wire logic [NROUTE-1:0]            route_out;
	wire logic [1:0][PLD_OUT-1:0]      pld_out;
	int                                failures = 0;
	int                                n_compared = 0;
	logic [CW-1:0]                     d;
	logic [7:0]                        e [8] = '{8'h5A, 8'h5B, 8'h59, 8'h69, 8'h4B, 8'h0A, 8'h5F, 8'h55};
	// clock
	always #2.5 clock = ~clock;
	pldc_cell u_dut (.clock(clock), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .route_in(route_in),
		.route_out(route_out), .chain_carry_in(1'b0), .chain_shift_in(1'b0), .chain_cond_in(1'b0),
		.chain_carry_out(), .chain_shift_out(), .chain_cond_out(), .pld_in(pld_in), .pld_and_true(pld_and_true),
		.pld_and_comp('0), .pld_or_sel(pld_or_sel), .pld_reg_sel(pld_reg_sel), .pld_out(pld_out));
	pldc_host_model u_host (.clock(clock), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid));
	task automatic chk(input logic [CW-1:0] got, input logic [CW-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		if (failures == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// select one config word for exactly one edge, then the idle word
	task automatic pulse(input logic [2:0] w);
		@(negedge clock);
		route_in[2:0] = w;
		@(negedge clock);
		route_in[2:0] = 3'h0;
	endtask
	task automatic t_regs();
		u_host.rd(ADDR_SETUP, d); chk(d, 16'h0070);
		u_host.rd(ADDR_STAT, d); chk(d, 16'h000C);
		u_host.rd(5'h1F, d); chk(d, 16'h0000);
		for (int i = 0; i < 4; i++) u_host.wr(ADDR_ACC0 + 5'(i), 16'h0010 + 16'(i));
		for (int i = 0; i < 4; i++) begin
			u_host.rd(ADDR_ACC0 + 5'(i), d); chk(d, 16'h0010 + 16'(i));
		end
	endtask
	task automatic t_alu();
		u_host.wr(ADDR_ACC0, 16'h005A);
		u_host.wr(ADDR_OPR0, 16'h000F);
		for (int i = 0; i < 8; i++) begin
			u_host.wr(ADDR_CFG | 5'h01, 16'h0640 | 16'(i));
			pulse(3'h1);
			u_host.rd(ADDR_ACC0 | 5'h01, d); chk(d, {8'h00, e[i]});
		end
		for (int k = 1; k < 4; k++) begin
			u_host.wr(ADDR_CFG | 5'h01, 16'h0600 | 16'(k << 7));
			pulse(3'h1);
			u_host.rd(ADDR_ACC0 | 5'h01, d); chk(d, k == 1 ? 16'h00B4 : k == 2 ? 16'h002D : 16'h00A5);
		end
		u_host.wr(ADDR_SETUP, 16'h0030);
		u_host.wr(ADDR_ACC0, 16'h000F);
		u_host.wr(ADDR_CFG | 5'h01, 16'h0641);
		pulse(3'h1);
		u_host.rd(ADDR_ACC0 | 5'h01, d); chk(d, 16'h0000);
		u_host.wr(ADDR_SETUP, 16'h00F0);
		u_host.wr(ADDR_MPOLY, 16'h0700);
		u_host.wr(ADDR_ACC0, 16'h00A5);
		u_host.wr(ADDR_CFG | 5'h01, 16'h0680);
		pulse(3'h1);
		u_host.rd(ADDR_ACC0 | 5'h01, d); chk(d, 16'h004D);
		u_host.wr(ADDR_MPOLY, 16'h0710);
		pulse(3'h1);
		u_host.rd(ADDR_ACC0 | 5'h01, d); chk(d, 16'h005D);
		u_host.wr(ADDR_MPOLY, 16'h0000);
		u_host.wr(ADDR_SETUP, 16'h0070);
	endtask
	task automatic t_queue();
		for (int i = 0; i < 5; i++) u_host.wr(ADDR_QUE0, 16'h0011 * 16'(i + 1));
		u_host.rd(ADDR_STAT, d); chk(d, 16'h0009);
		u_host.wr(ADDR_SETUP, 16'h0072);
		u_host.wr(ADDR_CFG | 5'h02, 16'h1000);
		for (int i = 0; i < 4; i++) begin
			pulse(3'h2);
			u_host.rd(ADDR_OPR0, d); chk(d, 16'h0011 * 16'(i + 1));
		end
		@(negedge clock);
		route_in[2:0] = 3'h2;
		u_host.rd(ADDR_STAT, d); chk(d, 16'h001C);
		route_in[2:0] = 3'h0;
		u_host.wr(ADDR_SETUP, 16'h0072);
		u_host.wr(ADDR_ACC0, 16'h003C);
		u_host.wr(ADDR_CFG | 5'h03, 16'h6000);
		pulse(3'h3);
		u_host.rd(ADDR_STAT, d); chk(d, 16'h000E);
		u_host.rd(ADDR_QUE0 | 5'h01, d); chk(d, 16'h003C);
		u_host.rd(ADDR_QUE0 | 5'h01, d); chk(d, 16'h003C);
		u_host.rd(ADDR_STAT, d); chk(d, 16'h000C);
	endtask
	task automatic t_cond();
		u_host.wr(ADDR_OSEL, 16'h0002);
		u_host.wr(ADDR_ACC0, 16'h0000);
		repeat (3) @(negedge clock);
		chk({15'h0000, route_out[0]}, 16'h0001);
		u_host.wr(ADDR_ACC0, 16'h0005);
		repeat (3) @(negedge clock);
		chk({15'h0000, route_out[0]}, 16'h0000);
		u_host.wr(ADDR_OSEL, 16'h0006);
		u_host.wr(ADDR_SETUP, 16'h0073);
		repeat (3) @(negedge clock);
		chk({15'h0000, route_out[0]}, 16'h0000);
		u_host.wr(ADDR_SETUP, 16'h0070);
	endtask
	task automatic t_pld();
		pld_and_true[0][0] = 12'h001;
		pld_or_sel[0][0] = 8'h01;
		pld_in[0][0] = 1'b1;
		repeat (3) @(negedge clock);
		chk({15'h0000, pld_out[0][0]}, 16'h0001);
		pld_in[0][0] = 1'b0;
		repeat (3) @(negedge clock);
		chk({15'h0000, pld_out[0][0]}, 16'h0000);
		pld_reg_sel[0][0] = 1'b1;
		pld_in[0][0] = 1'b1;
		repeat (4) @(negedge clock);
		chk({15'h0000, pld_out[0][0]}, 16'h0001);
	endtask
	// main sequence
	initial begin
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		repeat (5) @(negedge clock);
		t_regs();
		t_alu();
		t_queue();
		t_cond();
		t_pld();
		report_and_stop();
	end
	// watchdog
	initial begin
		#(20000 * 5);
		failures++;
		report_and_stop();
	end
endmodule

// ==== hdl/pldc_cell.sv ====
// top: programmable logic datapath cell, two logic arrays and an 8-bit datapath
`timescale 1ns/1ps
// Functional notes
// - each array: 12 inputs, 8 product terms, true or complement per input
// - each output ORs a chosen subset of the 8 terms, same width everywhere
// - two arrays, every output usable registered or combinational inside the cell, always registered at the pins
// - 8-bit datapath, one ALU operation per clock
// - six working registers all reachable from the system bus
// - accumulators are ALU sources, sinks, compare sources; data registers sources only
// - two four-byte queues load registers and capture accumulators or ALU
// - eight 16-bit config words, address from routing or from logic array 0, chosen every cycle
// - ALU: increment, decrement, add, subtract, AND, OR, XOR, pass
// - shift left, shift right, nibble swap and OR mask after the ALU
// - two masked comparators over accumulator and data register pairings
// - zero, all-ones and overflow conditions, selectable onto routing
// - programmable most significant bit for arithmetic and shifts
// - one CRC or pseudo random step per clock, programmable polynomial
// - each queue set as input buffer or output buffer independently
// - queue status selectable as a routed output
// - carry, shift data and condition chain to neighbouring cells
// - six routed inputs and six routed outputs
module pldc_cell
	import pldc_pkg::*;
(
	// clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  resetn,
	// system bus
	input  wire logic [AW-1:0]                         bus_addr,
	input  wire logic                                  bus_wr,
	input  wire logic                                  bus_rd,
	input  wire logic [CW-1:0]                         bus_wdata,
	output logic [CW-1:0]                              bus_rdata,
	output logic                                       bus_rvalid,
	// routing matrix
	input  wire logic [NROUTE-1:0]                     route_in,
	output logic [NROUTE-1:0]                          route_out,
	// chaining to neighbour cells
	input  wire logic                                  chain_carry_in,
	input  wire logic                                  chain_shift_in,
	input  wire logic                                  chain_cond_in,
	output logic                                       chain_carry_out,
	output logic                                       chain_shift_out,
	output logic                                       chain_cond_out,
	// logic arrays
	input  wire logic [1:0][PLD_IN-1:0]                pld_in,
	input  wire logic [1:0][PLD_PT-1:0][PLD_IN-1:0]    pld_and_true,
	input  wire logic [1:0][PLD_PT-1:0][PLD_IN-1:0]    pld_and_comp,
	input  wire logic [1:0][PLD_OUT-1:0][PLD_PT-1:0]   pld_or_sel,
	input  wire logic [1:0][PLD_OUT-1:0]               pld_reg_sel,
	output logic [1:0][PLD_OUT-1:0]                    pld_out
);
	logic                          rst_s1_q;
	logic                          rst_n_q;
	wire logic [1:0][PLD_PT-1:0]   pterm;
	wire logic [1:0][PLD_OUT-1:0]  sop;
	wire logic [1:0][PLD_OUT-1:0]  pld_val;
	logic [1:0][PLD_OUT-1:0]       pld_state_q;
	logic [CW-1:0]                 cfg_ram [CFG_WORDS];
	logic [CW-1:0]                 setup_q;
	logic [CW-1:0]                 mpoly_q;
	logic [CW-1:0]                 cmask_q;
	logic [CW-1:0]                 osel_q;
	logic [1:0][DW-1:0]            acc_q;
	logic [1:0][DW-1:0]            opr_q;
	logic                          carry_q;
	logic                          ovf_q;
	logic                          sout_q;
	logic [CAW-1:0]                cfg_addr;
	logic [CW-1:0]                 cw;
	pldc_func_t                    func;
	pldc_shift_t                   shift;
	pldc_qload_t                   qload;
	pldc_cap_t                     cap;
	logic [DW-1:0]                 opa;
	logic [DW-1:0]                 opb;
	logic [DW-1:0]                 addb;
	logic                          cin;
	logic [DW:0]                   sum;
	logic [DW-1:0]                 alu;
	logic [DW-1:0]                 shifted;
	logic [DW-1:0]                 keep;
	logic [DW-1:0]                 res;
	logic [2:0]                    msb;
	logic                          sin;
	logic                          sout;
	logic                          is_arith;
	logic                          ca_out;
	logic                          ovf;
	logic                          stall;
	logic                          cmp0;
	logic                          cmp1;
	logic [7:0]                    conds;
	logic [1:0]                    q_dir;
	logic [1:0]                    cap_req;
	logic [1:0]                    load_req;
	wire logic [1:0][DW-1:0]       q_data;
	wire logic [1:0]               q_valid;
	wire logic [1:0]               q_ready;
	logic [CW-1:0]                 rd_mux;

	// operand selection shared by both ALU inputs
	function automatic logic [DW-1:0] pick(input logic [1:0] s, input logic [1:0][DW-1:0] a,
		input logic [1:0][DW-1:0] d);
		return s[1] ? d[s[0]] : a[s[0]];
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// sum-of-products arrays
	genvar g, p, o;
	generate
		for (g = 0; g < 2; g++) begin : g_pld
			for (p = 0; p < PLD_PT; p++) begin : g_pt
				assign pterm[g][p] = (&(~pld_and_true[g][p] | pld_in[g]))
					& (&(~pld_and_comp[g][p] | ~pld_in[g]));
			end
			for (o = 0; o < PLD_OUT; o++) begin : g_or
				assign sop[g][o]     = |(pld_or_sel[g][o] & pterm[g]);
				assign pld_val[g][o] = pld_reg_sel[g][o] ? pld_state_q[g][o] : sop[g][o];
			end
		end
	endgenerate

	// array state bits and registered copy to the pins
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pld_state_q <= '0;
			pld_out     <= '0;
		end else begin
			pld_state_q <= sop;
			pld_out     <= pld_val;
		end
	end

	// configuration word chosen this cycle
	assign cfg_addr = setup_q[S_APLD] ? pld_val[0][CAW-1:0] : route_in[CAW-1:0];
	assign cw       = cfg_ram[cfg_addr];
	assign func     = pldc_func_t'(cw[F_FUNC +: 3]);
	assign shift    = pldc_shift_t'(cw[F_SHIFT +: 2]);
	assign qload    = pldc_qload_t'(cw[F_QLOAD +: 2]);
	assign cap      = pldc_cap_t'(cw[F_QCAP +: 2]);
	assign msb      = setup_q[S_MSB +: 3];
	assign opa      = pick(cw[F_SRCA +: 2], acc_q, opr_q);
	assign opb      = pick(cw[F_SRCB +: 2], acc_q, opr_q);

	// adder operand and carry for the arithmetic functions
	always_comb begin
		addb = opb;
		cin  = cw[F_CSEL] ? carry_q : (setup_q[S_CHC] ? chain_carry_in : route_in[4]);
		case (func)
			PLDC_INC: begin
				addb = '0;
				cin  = 1'b1;
			end
			PLDC_DEC: begin
				addb = ONES;
				cin  = 1'b0;
			end
			PLDC_SUB: begin
				addb = ~opb;
				cin  = 1'b1;
			end
			default: ;
		endcase
	end

	assign sum      = {1'b0, opa} + {1'b0, addb} + {{DW{1'b0}}, cin};
	assign is_arith = (func == PLDC_INC) || (func == PLDC_DEC) || (func == PLDC_ADD) || (func == PLDC_SUB);
	assign ca_out   = sum[4'(msb) + 4'h1];
	assign ovf      = is_arith && (opa[msb] ~^ addb[msb]) && (opa[msb] ^ alu[msb]);

	// ALU function select
	always_comb begin
		case (func)
			PLDC_PASS: alu = opa;
			PLDC_AND:  alu = opa & opb;
			PLDC_OR:   alu = opa | opb;
			PLDC_XOR:  alu = opa ^ opb;
			default:   alu = sum[DW-1:0];
		endcase
	end

	// shifter, CRC step, width trim and OR mask
	assign sin  = setup_q[S_CHS] ? chain_shift_in : (shift == SH_RIGHT ? route_in[5] : route_in[3]);
	assign keep = ONES >> (3'(DW - 1) - msb);
	always_comb begin
		shifted = alu;
		sout    = 1'b0;
		case (shift)
			SH_LEFT: begin
				shifted = {alu[DW-2:0], sin};
				sout    = alu[msb];
			end
			SH_RIGHT: begin
				shifted      = alu >> 1;
				shifted[msb] = sin;
				sout         = alu[0];
			end
			SH_SWAP: shifted = {alu[DW/2-1:0], alu[DW-1:DW/2]};
			default: ;
		endcase
		if (setup_q[S_CRC] && shift == SH_LEFT) begin
			shifted = {alu[DW-2:0], 1'b0} ^ ((alu[msb] ^ sin) ? mpoly_q[CW-1:DW] : '0);
		end
	end
	assign res = (shifted & keep) | mpoly_q[DW-1:0];

	// queue requests; datapath stalls when a needed queue cannot move
	assign q_dir       = setup_q[S_QDIR +: 2];
	assign cap_req[0]  = q_dir[0] && (cap == CAP_ACC || cap == CAP_ALU0);
	assign cap_req[1]  = q_dir[1] && (cap == CAP_ACC || cap == CAP_ALU1);
	assign load_req[0] = !q_dir[0] && (qload == Q_TO_ACC || qload == Q_TO_OPR);
	assign load_req[1] = !q_dir[1] && (qload == Q_TO_ACC || qload == Q_TO_OPR);
	assign stall       = |(load_req & ~q_valid) || |(cap_req & ~q_ready);

	// the two queues, direction per queue
	generate
		for (g = 0; g < 2; g++) begin : g_que
			pldc_fifo #(
				.W(DW),
				.D(QDEPTH)
			) u_fifo (
				.clock     (clock),
				.rst_n     (rst_n_q),
				.in_data   (q_dir[g] ? (cap == CAP_ACC ? acc_q[g] : res) : bus_wdata[DW-1:0]),
				.in_valid  (q_dir[g] ? (cap_req[g] && !stall)
					: (bus_wr && bus_addr == ADDR_QUE0 + AW'(g))),
				.in_ready  (q_ready[g]),
				.out_data  (q_data[g]),
				.out_valid (q_valid[g]),
				.out_ready (q_dir[g] ? (bus_rd && bus_addr == ADDR_QUE0 + AW'(g))
					: (load_req[g] && !stall))
			);
		end
	endgenerate

	// accumulators: bus write, then queue load, then ALU result
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			acc_q <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (bus_wr && bus_addr == ADDR_ACC0 + AW'(i)) acc_q[i] <= bus_wdata[DW-1:0];
				else if (!stall && qload == Q_TO_ACC && load_req[i]) acc_q[i] <= q_data[i];
				else if (!stall && cw[F_WE] && cw[F_DEST] == 1'(i)) acc_q[i] <= res;
			end
		end
	end

	// data registers: bus write or queue load only
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			opr_q <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (bus_wr && bus_addr == ADDR_OPR0 + AW'(i)) opr_q[i] <= bus_wdata[DW-1:0];
				else if (!stall && qload == Q_TO_OPR && load_req[i]) opr_q[i] <= q_data[i];
			end
		end
	end

	// registered carry, overflow and shift out
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			carry_q <= 1'b0;
			ovf_q   <= 1'b0;
			sout_q  <= 1'b0;
		end else if (!stall) begin
			if (is_arith) carry_q <= ca_out;
			if (is_arith) ovf_q <= ovf;
			if (shift == SH_LEFT || shift == SH_RIGHT) sout_q <= sout;
		end
	end

	// setup registers and configuration memory
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			setup_q <= RST_SETUP;
			mpoly_q <= RST_WORD;
			cmask_q <= RST_WORD;
			osel_q  <= RST_WORD;
			for (int i = 0; i < CFG_WORDS; i++) cfg_ram[i] <= RST_WORD;
		end else if (bus_wr) begin
			if (bus_addr == ADDR_SETUP) setup_q <= bus_wdata;
			else if (bus_addr == ADDR_MPOLY) mpoly_q <= bus_wdata;
			else if (bus_addr == ADDR_CMASK) cmask_q <= bus_wdata;
			else if (bus_addr == ADDR_OSEL) osel_q <= bus_wdata;
			else if (bus_addr >= ADDR_CFG) cfg_ram[bus_addr[CAW-1:0]] <= bus_wdata;
		end
	end

	// masked compares and condition vector
	assign cmp0  = ((acc_q[0] ^ (setup_q[S_PAIR0] ? acc_q[1] : opr_q[0])) & cmask_q[DW-1:0]) == '0
		&& (!setup_q[S_CHK] || chain_cond_in);
	assign cmp1  = ((acc_q[1] ^ (setup_q[S_PAIR1] ? acc_q[0] : opr_q[1])) & cmask_q[CW-1:DW]) == '0;
	assign conds = {q_dir[1] ? q_valid[1] : q_ready[1], q_dir[0] ? q_valid[0] : q_ready[0], ovf_q,
		acc_q[0] == ONES, acc_q[1] == '0, acc_q[0] == '0, cmp1, cmp0};

	// routed and chained outputs
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			route_out       <= '0;
			chain_carry_out <= 1'b0;
			chain_shift_out <= 1'b0;
			chain_cond_out  <= 1'b0;
		end else begin
			for (int k = 0; k < NSEL; k++) route_out[k] <= conds[osel_q[SELW*k +: SELW]];
			route_out[NSEL] <= sout_q;
			chain_carry_out <= ca_out;
			chain_shift_out <= sout;
			chain_cond_out  <= cmp0;
		end
	end

	// read data selection
	always_comb begin
		if (bus_addr == ADDR_ACC0 || bus_addr == ADDR_ACC0 + 5'h01) rd_mux = CW'(acc_q[bus_addr[0]]);
		else if (bus_addr == ADDR_OPR0 || bus_addr == ADDR_OPR0 + 5'h01) rd_mux = CW'(opr_q[bus_addr[0]]);
		else if (bus_addr == ADDR_QUE0 || bus_addr == ADDR_QUE0 + 5'h01) rd_mux = CW'(q_data[bus_addr[0]]);
		else if (bus_addr == ADDR_SETUP) rd_mux = setup_q;
		else if (bus_addr == ADDR_MPOLY) rd_mux = mpoly_q;
		else if (bus_addr == ADDR_CMASK) rd_mux = cmask_q;
		else if (bus_addr == ADDR_OSEL) rd_mux = osel_q;
		else if (bus_addr == ADDR_STAT) rd_mux = CW'({stall, q_ready, q_valid});
		else if (bus_addr >= ADDR_CFG) rd_mux = cfg_ram[bus_addr[CAW-1:0]];
		else rd_mux = '0;
	end

	// registered bus read answer
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bus_rdata  <= '0;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= bus_rd;
			if (bus_rd) bus_rdata <= rd_mux;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n_q);

	logic plain;
	assign plain = !stall && !bus_wr && !setup_q[S_CRC] && mpoly_q[DW-1:0] == '0 && msb == 3'h7
		&& qload == Q_NONE && cw[F_WE];

	sequence s_starved;
		load_req[0] && !q_valid[0] && (qload == Q_TO_ACC || qload == Q_TO_OPR);
	endsequence

	a_alu_inc: assert property (
		plain && shift == SH_NONE && func == PLDC_INC |=> acc_q[$past(cw[F_DEST])] == $past(opa) + 8'h01)
		else $error("increment result wrong");
	a_alu_xor: assert property (
		plain && shift == SH_NONE && func == PLDC_XOR |=> acc_q[$past(cw[F_DEST])] == ($past(opa) ^ $past(opb)))
		else $error("xor result wrong");
	a_nibble_swap: assert property (
		plain && shift == SH_SWAP && func == PLDC_PASS
		|=> acc_q[$past(cw[F_DEST])] == {$past(opa[3:0]), $past(opa[7:4])})
		else $error("nibble swap wrong");
	a_var_msb: assert property (
		!stall && !bus_wr && !setup_q[S_CRC] && shift == SH_NONE && func == PLDC_INC && qload == Q_NONE
		&& cw[F_WE]
		|=> acc_q[$past(cw[F_DEST])] == ((($past(opa) + 8'h01) & $past(keep)) | $past(mpoly_q[7:0])))
		else $error("msb trim or mask wrong");
	a_crc_step: assert property (
		!stall && !bus_wr && setup_q[S_CRC] && shift == SH_LEFT && func == PLDC_PASS && msb == 3'h7
		&& mpoly_q[7:0] == '0 && qload == Q_NONE && cw[F_WE]
		|=> acc_q[$past(cw[F_DEST])] == (($past(opa) << 1) ^ ($past(opa[7] ^ sin) ? $past(mpoly_q[15:8]) : 8'h00)))
		else $error("crc step wrong");
	a_cmp_route: assert property (
		osel_q[2:0] == C_CMP0 && cmask_q[7:0] == '0 && !setup_q[S_CHK] |=> route_out[0])
		else $error("fully masked compare not true");
	a_zero_route: assert property (
		osel_q[2:0] == C_ZERO0 |=> route_out[0] == ($past(acc_q[0]) == 8'h00))
		else $error("zero detect not routed");
	a_load_stall: assert property (
		s_starved ##0 !bus_wr |=> $stable(acc_q[0]) ##0 $stable(opr_q[0]) ##0 $stable(carry_q))
		else $error("starved load did not stall");
	a_qstat_route: assert property (
		osel_q[2:0] == C_QST0 && q_dir[0] |=> route_out[0] == $past(q_valid[0]))
		else $error("queue status not routed");
endmodule

// ==== hdl/pldc_fifo.sv ====
// byte queue with valid and ready on both sides
`timescale 1ns/1ps
module pldc_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// filling side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// draining side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int PW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0]   cnt_q;
	logic          push;
	logic          pop;

	// honest flags; full refuses, empty drops out_valid
	assign in_ready  = cnt_q != (PW+1)'(D);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem[out_valid ? rd_q : rd_q - 1'b1]; // empty shows the last byte taken
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage, written only on an accepted push
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// pointers and fill count; depth is a power of two
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			if (push && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end

	a_fifo_refuse: assert property (@(posedge clock) disable iff (!rst_n)
		(!in_ready && in_valid && !out_ready) |=> (cnt_q == $past(cnt_q)) && $stable(out_data))
		else $error("push into full queue changed contents");
	a_fifo_order: assert property (@(posedge clock) disable iff (!rst_n)
		(push && !out_valid) |=> out_valid && (out_data == $past(in_data)))
		else $error("first byte into empty queue not presented");
endmodule

// ==== hdl/pldc_pkg.sv ====
// package: constants and types of the programmable logic datapath cell
package pldc_pkg;
	// widths and sizes
	localparam int DW        = 8;
	localparam int CW        = 16;
	localparam int AW        = 5;
	localparam int QDEPTH    = 4;
	localparam int CFG_WORDS = 8;
	localparam int CAW       = 3;
	localparam int PLD_IN    = 12;
	localparam int PLD_PT    = 8;
	localparam int PLD_OUT   = 4;
	localparam int NROUTE    = 6;
	localparam int NSEL      = 5;
	localparam int SELW      = 3;
	// bus word addresses
	localparam logic [AW-1:0] ADDR_ACC0  = 5'h00;
	localparam logic [AW-1:0] ADDR_OPR0  = 5'h02;
	localparam logic [AW-1:0] ADDR_QUE0  = 5'h04;
	localparam logic [AW-1:0] ADDR_SETUP = 5'h06;
	localparam logic [AW-1:0] ADDR_MPOLY = 5'h07;
	localparam logic [AW-1:0] ADDR_CMASK = 5'h08;
	localparam logic [AW-1:0] ADDR_OSEL  = 5'h09;
	localparam logic [AW-1:0] ADDR_STAT  = 5'h0A;
	localparam logic [AW-1:0] ADDR_CFG   = 5'h10;
	// dynamic configuration word fields
	localparam int F_FUNC  = 0;
	localparam int F_SRCA  = 3;
	localparam int F_SRCB  = 5;
	localparam int F_SHIFT = 7;
	localparam int F_DEST  = 9;
	localparam int F_WE    = 10;
	localparam int F_QLOAD = 11;
	localparam int F_QCAP  = 13;
	localparam int F_CSEL  = 15;
	// static setup register fields
	localparam int S_QDIR  = 0;
	localparam int S_PAIR0 = 2;
	localparam int S_PAIR1 = 3;
	localparam int S_MSB   = 4;
	localparam int S_CRC   = 7;
	localparam int S_CHC   = 8;
	localparam int S_CHS   = 9;
	localparam int S_CHK   = 10;
	localparam int S_APLD  = 11;
	// values after reset
	localparam logic [CW-1:0] RST_SETUP = 16'h0070;
	localparam logic [CW-1:0] RST_WORD  = 16'h0000;
	localparam logic [DW-1:0] ONES      = 8'hFF;
	typedef enum logic [2:0] {
		PLDC_PASS, PLDC_INC, PLDC_DEC, PLDC_ADD,
		PLDC_SUB, PLDC_AND, PLDC_OR, PLDC_XOR
	} pldc_func_t;
	typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} pldc_shift_t;
	typedef enum logic [1:0] {Q_NONE, Q_TO_ACC, Q_TO_OPR, Q_RSVD} pldc_qload_t;
	typedef enum logic [1:0] {CAP_NONE, CAP_ACC, CAP_ALU0, CAP_ALU1} pldc_cap_t;
	typedef enum logic [2:0] {
		C_CMP0, C_CMP1, C_ZERO0, C_ZERO1,
		C_ONES0, C_OVF, C_QST0, C_QST1
	} pldc_cond_t;
endpackage
